// >>> shared/dtc_cfg.svh
// Constants for the DRAM termination controller: register offsets, resets, latency figures.
// Assumes it is included once per compilation unit by bare name.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Register byte addresses
`define DTC_ADDR_MODE    32'h0000_0000
`define DTC_ADDR_LAT     32'h0000_0004
`define DTC_ADDR_ZQLEN   32'h0000_0008
`define DTC_ADDR_STATUS  32'h0000_000C

// Reset values
`define DTC_MODE_RST     12'h000
`define DTC_LAT_RST      12'h3C9
`define DTC_ZQLEN_RST    16'h0080

// Status field positions
`define DTC_ST_SR_BIT    2
`define DTC_ST_ZQ_BIT    3
`define DTC_ST_RX_BIT    4
`define DTC_ST_EN_BIT    5
`define DTC_ST_ERR_BIT   8

// Read turn-off offsets and extensions, and ODT synchroniser latency, in clocks
`define DTC_X_1T         4'h2
`define DTC_X_2T         4'h3
`define DTC_Y_CRC        4'h1
`define DTC_HALF_BL8     4'h4
`define DTC_HALF_BC4     4'h2
`define DTC_SYNC_LAT     4'h2

// Write termination windows (ODTLcwn minus ODTLcnw)
`define DTC_WLEN_BL8_1T  4'h6
`define DTC_WLEN_BC4_1T  4'h4
`define DTC_WLEN_BL8_2T  4'h7
`define DTC_WLEN_BC4_2T  4'h5
`define DTC_WLEN_CRC_1T  4'h7
`define DTC_WLEN_CRC_2T  4'h8

// Delay line geometry
`define DTC_DLY_DEPTH    64
`define DTC_TAP_W        6

// Effective termination values in ohms
`define DTC_OHM_240      8'hF0
`define DTC_OHM_120      8'h78
`define DTC_OHM_80       8'h50
`define DTC_OHM_60       8'h3C
`define DTC_OHM_48       8'h30
`define DTC_OHM_40       8'h28
`define DTC_OHM_34       8'h22

`endif

// >>> shared/dtc_pkg.sv
// Types shared by the DRAM termination controller files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dtc_pkg;

   typedef enum logic [1:0] {
      DTC_HIZ  = 2'b00,
      DTC_PARK = 2'b01,
      DTC_NOM  = 2'b10,
      DTC_WRT  = 2'b11
   } dtc_state_type;

   typedef enum logic [2:0] {
      DTC_CMD_NOP  = 3'b000,
      DTC_CMD_RD   = 3'b001,
      DTC_CMD_WR   = 3'b010,
      DTC_CMD_SRE  = 3'b011,
      DTC_CMD_SRX  = 3'b100,
      DTC_CMD_ZQCL = 3'b101,
      DTC_CMD_ZQCS = 3'b110
   } dtc_cmd_code_type;

   typedef struct packed {
      dtc_cmd_code_type code;
      logic             bc4;
   } dtc_cmd_type;

   typedef struct packed {
      logic       x8;
      logic       crc_en;
      logic       pre2t;
      logic       tdqs_en;
      logic [2:0] park;
      logic [1:0] wr;
      logic [2:0] nom;
   } dtc_mode_type;

   typedef struct packed {
      logic [5:0] rl;
      logic [5:0] wl;
   } dtc_lat_type;

   typedef struct packed {
      dtc_state_type state;
      logic [2:0]    code;
      logic [7:0]    ohms;
      logic          tdqs;
   } dtc_term_type;

endpackage
`default_nettype wire

// >>> rtl/dtc_delay_line.sv
// Shift-register delay line with a run-time tap, one entry per clock.
// Assumes hclk domain inputs; cke freezes the line.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_cfg.svh"

module dtc_delay_line #(
   parameter int unsigned W = 2
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  cke,
   input  wire logic [W-1:0]          din,
   input  wire logic [`DTC_TAP_W-1:0] tap,
   output logic      [W-1:0]          dout
);

   logic [W-1:0] line_q [`DTC_DLY_DEPTH];

   // Entry i holds the input seen i+1 enabled edges ago
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `DTC_DLY_DEPTH; i++) begin
            line_q[i] <= '0;
         end
      end else if (cke) begin
         line_q[0] <= din;
         for (int i = 1; i < `DTC_DLY_DEPTH; i++) begin
            line_q[i] <= line_q[i-1];
         end
      end
   end

   // Combinational tap keeps the latency exact for any setting
   assign dout = line_q[tap];

endmodule
`default_nettype wire

// >>> rtl/dtc_term_ctrl.sv
// DRAM on-die termination state controller with an AHB-Lite register slave.
// Assumes commands arrive on hclk from logic; the ODT pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_cfg.svh"

// Operation
// - ODT held low during ZQ calibration; device keeps parked termination.
// - On x8 parts, termination strobe pair terminates only when enabled.
// - Self-refresh forces Hi-Z regardless of mode settings.
// - ODT pin ignored when nominal field is zero or in self-refresh.
// - Termination counts enabled when nominal, write or park field non-zero.
// - Enabled write termination applies for the write window regardless of ODT.
// - Nominal termination switches on when ODT sampled high and field enabled.
// - ODT low: park value if enabled, otherwise Hi-Z.
// - Read disables termination from RL-X for BL/2+X+Y clocks.
// - X is two clocks for 1-clock preamble, three for 2-clock.
// - Y is zero with write CRC off, one with it on.
// - Priority: read disable, write, nominal, park.
// - ODT receiver powered down when nominal termination is disabled.
// - Selectable values are 240, 120, 80, 60, 48, 40 and 34 ohms.
// - Nominal termination follows ODT after WL-2 clocks, 1-clock preamble.
// - Write termination starts WL-2 or WL-3 clocks after the write.
module dtc_term_ctrl (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 cke,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic      [31:0]          hrdata,
   input  wire dtc_pkg::dtc_cmd_type cmd,
   input  wire logic                 odt_pin,
   output logic                      odt_rx_en,
   output dtc_pkg::dtc_term_type     term
);
   import dtc_pkg::*;

   // Latency tap: base - sub - 1, floored at zero
   function automatic logic [`DTC_TAP_W-1:0] lat_tap(input logic [5:0] base, input logic [3:0] sub);
      logic [6:0] t;
      t = {1'b0, base} - {3'b000, sub} - 7'h01;
      return t[6] ? 6'h00 : t[5:0];
   endfunction

   // Field code to effective ohms; write field uses its own table
   function automatic logic [7:0] rtt_ohms(input logic [2:0] code, input logic is_wr);
      logic [7:0] o;
      o = 8'h00;
      if (is_wr) begin
         unique case (code[1:0])
            2'b00: o = 8'h00;
            2'b01: o = `DTC_OHM_120;
            2'b10: o = `DTC_OHM_240;
            2'b11: o = `DTC_OHM_80;
         endcase
      end else begin
         unique case (code)
            3'b000: o = 8'h00;
            3'b001: o = `DTC_OHM_60;
            3'b010: o = `DTC_OHM_120;
            3'b011: o = `DTC_OHM_40;
            3'b100: o = `DTC_OHM_240;
            3'b101: o = `DTC_OHM_48;
            3'b110: o = `DTC_OHM_80;
            3'b111: o = `DTC_OHM_34;
         endcase
      end
      return o;
   endfunction

   dtc_mode_type  mode_q, mode_d;
   dtc_lat_type   lat_q, lat_d;
   logic [15:0]   zqlen_q, zqlen_d;
   logic          err_q, err_d;
   logic          wr_pend_q;
   logic [31:0]   addr_q;
   logic [31:0]   rd_val;
   logic          odt_m_q, odt_s_q;
   logic          sr_q;
   logic [15:0]   zq_cnt_q;
   logic [3:0]    rd_cnt_q, wr_cnt_q;
   logic          zq_busy, odt_live, term_en;
   logic [3:0]    x_off, y_ext, rd_len, wr_len;
   logic [1:0]    rd_dly, wr_dly;
   logic [0:0]    odt_dly;
   logic          rd_hit, wr_hit, rd_on, wr_on, nom_on;
   logic          cmd_rd, cmd_wr;
   dtc_state_type st_d;
   dtc_term_type  term_d;

   // Bus stalls while the clock enable is low, since all state is frozen
   assign hreadyout = cke;
   assign hresp     = 1'b0;

   // Address phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 32'h0000_0000;
         hrdata    <= 32'h0000_0000;
      end else if (cke && hready) begin
         wr_pend_q <= hsel && htrans[1] && hwrite;
         addr_q    <= haddr;
         hrdata    <= (hsel && htrans[1] && !hwrite) ? rd_val : 32'h0000_0000;
      end
   end

   // Read mux sees next values so a read right after a write is current
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (haddr)
         `DTC_ADDR_MODE:   rd_val = {20'h0_0000, mode_d};
         `DTC_ADDR_LAT:    rd_val = {20'h0_0000, lat_d};
         `DTC_ADDR_ZQLEN:  rd_val = {16'h0000, zqlen_d};
         `DTC_ADDR_STATUS: begin
            rd_val[1:0]             = term.state;
            rd_val[`DTC_ST_SR_BIT]  = sr_q;
            rd_val[`DTC_ST_ZQ_BIT]  = zq_busy;
            rd_val[`DTC_ST_RX_BIT]  = odt_rx_en;
            rd_val[`DTC_ST_EN_BIT]  = term_en;
            rd_val[`DTC_ST_ERR_BIT] = err_d;
         end
         default:          rd_val = 32'h0000_0000;
      endcase
   end

   // Data phase writes; unmapped addresses are ignored
   always_comb begin
      mode_d  = mode_q;
      lat_d   = lat_q;
      zqlen_d = zqlen_q;
      if (wr_pend_q && cke) begin
         if (addr_q == `DTC_ADDR_MODE) mode_d = dtc_mode_type'(hwdata[11:0]);
         if (addr_q == `DTC_ADDR_LAT) lat_d = dtc_lat_type'(hwdata[11:0]);
         if (addr_q == `DTC_ADDR_ZQLEN) zqlen_d = hwdata[15:0];
      end
   end

   // ODT high during calibration is a controller fault; set beats clear
   always_comb begin
      err_d = err_q;
      if (wr_pend_q && cke && addr_q == `DTC_ADDR_STATUS && hwdata[`DTC_ST_ERR_BIT]) err_d = 1'b0;
      if (cke && zq_busy && odt_s_q) err_d = 1'b1;
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q  <= dtc_mode_type'(`DTC_MODE_RST);
         lat_q   <= dtc_lat_type'(`DTC_LAT_RST);
         zqlen_q <= `DTC_ZQLEN_RST;
         err_q   <= 1'b0;
      end else begin
         mode_q  <= mode_d;
         lat_q   <= lat_d;
         zqlen_q <= zqlen_d;
         err_q   <= err_d;
      end
   end

   // Pin synchroniser for the ODT input
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odt_m_q <= 1'b0;
         odt_s_q <= 1'b0;
      end else if (cke) begin
         odt_m_q <= odt_pin;
         odt_s_q <= odt_m_q;
      end
   end

   // Receiver off saves power when nominal termination is unused
   assign odt_rx_en = (mode_q.nom != 3'b000);
   assign odt_live  = odt_s_q && odt_rx_en && !sr_q;
   assign term_en   = (mode_q.nom != 3'b000) || (mode_q.wr != 2'b00) || (mode_q.park != 3'b000);
   assign zq_busy   = (zq_cnt_q != 16'h0000);

   // Preamble and CRC adjustments
   assign x_off  = mode_q.pre2t ? `DTC_X_2T : `DTC_X_1T;
   assign y_ext  = mode_q.crc_en ? `DTC_Y_CRC : 4'h0;
   assign rd_len = (rd_dly[0] ? `DTC_HALF_BC4 : `DTC_HALF_BL8) + x_off + y_ext;

   // Write window length by burst, CRC and preamble
   always_comb begin
      if (mode_q.crc_en) wr_len = mode_q.pre2t ? `DTC_WLEN_CRC_2T : `DTC_WLEN_CRC_1T;
      else if (wr_dly[0]) wr_len = mode_q.pre2t ? `DTC_WLEN_BC4_2T : `DTC_WLEN_BC4_1T;
      else wr_len = mode_q.pre2t ? `DTC_WLEN_BL8_2T : `DTC_WLEN_BL8_1T;
   end

   // Commands other than exit are not taken in self-refresh
   assign cmd_rd = (cmd.code == DTC_CMD_RD) && !sr_q;
   assign cmd_wr = (cmd.code == DTC_CMD_WR) && !sr_q && (mode_q.wr != 2'b00);

   // Read commands delayed to RL-X
   dtc_delay_line #(.W(2)) u_rd_line (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cke     (cke),
      .din     ({cmd_rd, cmd.bc4}),
      .tap     (lat_tap(lat_q.rl, x_off)),
      .dout    (rd_dly)
   );

   // Write commands delayed to WL-X
   dtc_delay_line #(.W(2)) u_wr_line (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cke     (cke),
      .din     ({cmd_wr, cmd.bc4}),
      .tap     (lat_tap(lat_q.wl, x_off)),
      .dout    (wr_dly)
   );

   // Synchroniser stages count toward the WL-X ODT latency
   dtc_delay_line #(.W(1)) u_odt_line (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cke     (cke),
      .din     (odt_live),
      .tap     (lat_tap(lat_q.wl, x_off + `DTC_SYNC_LAT)),
      .dout    (odt_dly)
   );

   assign rd_hit = rd_dly[1];
   assign wr_hit = wr_dly[1];
   assign rd_on  = rd_hit || (rd_cnt_q != 4'h0);
   assign wr_on  = wr_hit || (wr_cnt_q != 4'h0);
   assign nom_on = odt_dly[0] && (mode_q.nom != 3'b000) && !sr_q;

   // Window counters; a new hit restarts the window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_cnt_q <= 4'h0;
         wr_cnt_q <= 4'h0;
      end else if (cke) begin
         if (rd_hit) rd_cnt_q <= rd_len - 4'h1;
         else if (rd_cnt_q != 4'h0) rd_cnt_q <= rd_cnt_q - 4'h1;
         if (wr_hit) wr_cnt_q <= wr_len - 4'h1;
         else if (wr_cnt_q != 4'h0) wr_cnt_q <= wr_cnt_q - 4'h1;
      end
   end

   // Self-refresh and calibration tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_q     <= 1'b0;
         zq_cnt_q <= 16'h0000;
      end else if (cke) begin
         if (cmd.code == DTC_CMD_SRE) sr_q <= 1'b1;
         else if (cmd.code == DTC_CMD_SRX) sr_q <= 1'b0;
         if (!sr_q && (cmd.code == DTC_CMD_ZQCL || cmd.code == DTC_CMD_ZQCS)) zq_cnt_q <= zqlen_q;
         else if (zq_busy) zq_cnt_q <= zq_cnt_q - 16'h0001;
      end
   end

   // Fixed priority resolution of the termination source
   always_comb begin
      if (sr_q) st_d = DTC_HIZ;
      else if (zq_busy) st_d = (mode_q.park != 3'b000) ? DTC_PARK : DTC_HIZ;
      else if (rd_on) st_d = DTC_HIZ;
      else if (wr_on) st_d = DTC_WRT;
      else if (nom_on) st_d = DTC_NOM;
      else if (mode_q.park != 3'b000) st_d = DTC_PARK;
      else st_d = DTC_HIZ;
   end

   // Value and strobe-pair termination follow the chosen source
   always_comb begin
      term_d.state = st_d;
      term_d.code  = 3'b000;
      unique case (st_d)
         DTC_HIZ:  term_d.code = 3'b000;
         DTC_PARK: term_d.code = mode_q.park;
         DTC_NOM:  term_d.code = mode_q.nom;
         DTC_WRT:  term_d.code = {1'b0, mode_q.wr};
      endcase
      term_d.ohms = rtt_ohms(term_d.code, st_d == DTC_WRT);
      term_d.tdqs = mode_q.x8 && mode_q.tdqs_en && (st_d != DTC_HIZ);
   end

   // One registered state per enabled edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) term <= '0;
      else if (cke) term <= term_d;
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_sr_hiz: assert property (cke && sr_q |=> term.state == DTC_HIZ)
      else $error("self-refresh did not give Hi-Z");
   a_zq_park: assert property (cke && !sr_q && zq_busy && mode_q.park != 3'b000 |=> term.state == DTC_PARK)
      else $error("calibration did not hold park");
   a_read_hiz: assert property (cke && !sr_q && !zq_busy && rd_on |=> term.state == DTC_HIZ)
      else $error("read window not Hi-Z");
   a_read_len: assert property (cke && rd_hit && !rd_dly[0] && !mode_q.pre2t && !mode_q.crc_en
                                |=> rd_cnt_q == 4'h5)
      else $error("read off window length wrong");
   a_write_len: assert property (cke && wr_hit && !wr_dly[0] && !mode_q.pre2t && !mode_q.crc_en
                                 |=> wr_cnt_q == 4'h5)
      else $error("write window length wrong");
   a_write_prio: assert property (cke && !sr_q && !zq_busy && !rd_on && wr_on |=> term.state == DTC_WRT)
      else $error("write termination lost priority");
   a_nom_ignore: assert property (cke && mode_q.nom == 3'b000 |-> !odt_rx_en ##1 term.state != DTC_NOM)
      else $error("ODT honoured while nominal disabled");
   a_park_idle: assert property (cke && !sr_q && !zq_busy && !rd_on && !wr_on && !nom_on
                                 |=> term.state == ($past(mode_q.park) != 3'b000 ? DTC_PARK : DTC_HIZ))
      else $error("idle termination wrong");
   a_tdqs_gate: assert property (term.tdqs && $past(cke) |-> $past(mode_q.x8) && $past(mode_q.tdqs_en)
                                 && term.state != DTC_HIZ)
      else $error("strobe pair terminated wrongly");
   a_err_set: assert property (cke && zq_busy && odt_s_q |=> err_q)
      else $error("pin high in calibration not flagged");
   a_zq_load: assert property (cke && !sr_q && cmd.code == DTC_CMD_ZQCL |=> zq_cnt_q == $past(zqlen_q))
      else $error("calibration length not loaded");
   a_ohms_set: assert property (term.state != DTC_HIZ && term.code != 3'b000 |-> term.ohms inside {
                                `DTC_OHM_240, `DTC_OHM_120, `DTC_OHM_80, `DTC_OHM_60,
                                `DTC_OHM_48, `DTC_OHM_40, `DTC_OHM_34})
      else $error("termination value not selectable");

   c_read_off:  cover property (cke && rd_hit ##1 term.state == DTC_HIZ);
   c_write_on:  cover property (term.state == DTC_WRT);
   c_nom_on:    cover property (term.state == DTC_NOM);
   c_zq_run:    cover property (zq_busy && term.state == DTC_PARK);
   c_sr_enter:  cover property (sr_q && term.state == DTC_HIZ);

endmodule
`default_nettype wire

// >>> tb/dtc_ctl_model.sv
// Controller-side model: drives cke, commands and the ODT pin.
// Assumes the bench calls its tasks hierarchically, in step with hclk.
`timescale 1ns/10ps
`default_nettype none

module dtc_ctl_model (
   input  wire logic                hclk,
   output var  logic                cke,
   output var  dtc_pkg::dtc_cmd_type cmd,
   output var  logic                odt_pin
);
   import dtc_pkg::*;

   // Idle values; cke drops only outside calibration
   initial begin
      cke = 1'b1;
      cmd = '{DTC_CMD_NOP, 1'b0};
      odt_pin = 1'b0;
   end

   // One command for one clock, then NOP; returns at the sampling edge
   // No bank state is modelled, so precharge-before-calibration holds
   task automatic issue(input dtc_cmd_code_type c, input logic bc4);
      @(posedge hclk);
      if (c == DTC_CMD_ZQCL || c == DTC_CMD_ZQCS) odt_pin <= 1'b0;
      cmd <= '{c, bc4};
      @(posedge hclk);
      cmd <= '{DTC_CMD_NOP, 1'b0};
   endtask

   // Clock enable changes just after an edge; the bench never drops it in calibration
   task automatic set_cke(input logic v);
      @(posedge hclk);
      cke <= v;
   endtask

   // Pin level changes just after an edge, like a real controller
   task automatic set_odt(input logic v);
      @(posedge hclk);
      odt_pin <= v;
   endtask
endmodule
`default_nettype wire

// >>> tb/dtc_term_ctrl_tb.sv
// Self-checking bench for the termination controller.
// Assumes the controller model file and the shared package are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_cfg.svh"

module dtc_term_ctrl_tb;
   import dtc_pkg::*;

   logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, odt_rx_en, cke, odt_pin;
   logic        [31:0] haddr, hwdata, hrdata, rd;
   logic        [1:0]  htrans;
   logic        [2:0]  hsize;
   dtc_cmd_type        cmd;
   dtc_term_type       term;
   int                 n_errors, n_checks;
   // Expected tables: park ohms per code, then per-mode window figures
   logic        [7:0]  ohm [8] = '{8'h00, `DTC_OHM_60, `DTC_OHM_120, `DTC_OHM_40,
                                   `DTC_OHM_240, `DTC_OHM_48, `DTC_OHM_80, `DTC_OHM_34};
   logic        [31:0] mtab [4] = '{32'h0000_002A, 32'h0000_042A, 32'h0000_022A, 32'h0000_062A};
   int                 wst [4] = '{7, 7, 6, 6};
   int                 wln [4] = '{6, 7, 7, 8};
   int                 rst [4] = '{13, 13, 12, 12};
   int                 rln [4] = '{6, 7, 7, 8};

   dtc_ctl_model u_ctl (.hclk(hclk), .cke(cke), .cmd(cmd), .odt_pin(odt_pin));

   dtc_term_ctrl DUT (
      .hclk(hclk), .hresetn(hresetn), .cke(cke), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .cmd(cmd), .odt_pin(odt_pin), .odt_rx_en(odt_rx_en), .term(term)
   );

   // 125 MHz clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_errors++;
      end
   endtask

   // One AHB single transfer; waits on hready, read data taken at data-phase edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic rreg(input logic [31:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   // Let n edges pass, then look once their updates have landed
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   task automatic st(input dtc_state_type s);
      chk("state", 32'(s), 32'(term.state));
   endtask

   task automatic tdone(input string nm);
      $display("test %s done", nm);
   endtask

   // Edge-by-edge view of one command: state a for edges s..s+l-1, else o
   task automatic win(input dtc_cmd_code_type c, input logic b4, input int s, input int l,
                      input dtc_state_type a, input dtc_state_type o);
      u_ctl.issue(c, b4);
      for (int k = 1; k <= 22; k++) begin
         wt(1);
         chk("window", (k >= s && k < s + l) ? 32'(a) : 32'(o), 32'(term.state));
      end
   endtask

   // Hang guard: the whole run is far shorter than this
   initial begin
      repeat (20000) @(posedge hclk);
      n_errors++;
      $display("BAD watchdog exp done got timeout");
      end_sim();
   end

   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      n_errors = 0;
      n_checks = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      wt(2);
      st(DTC_HIZ);
      rreg(`DTC_ADDR_MODE, 32'h0000_0000, "mode");
      rreg(`DTC_ADDR_LAT, 32'h0000_03C9, "lat");
      rreg(`DTC_ADDR_ZQLEN, 32'h0000_0080, "zqlen");
      bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
      rreg(32'h0000_0010, 32'h0000_0000, "unmapped");
      rreg(`DTC_ADDR_STATUS, 32'h0000_0000, "status");
      tdone("regs");
      for (int c = 1; c < 8; c++) begin
         bus(1'b1, `DTC_ADDR_MODE, 32'(c) << 5);
         wt(3);
         st(DTC_PARK);
         chk("ohms", 32'(ohm[c]), 32'(term.ohms));
      end
      rreg(`DTC_ADDR_STATUS, 32'h0000_0021, "status");
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_0920);
      wt(3);
      chk("tdqs", 32'h0000_0001, 32'(term.tdqs));
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_0820);
      wt(3);
      chk("tdqs", 32'h0000_0000, 32'(term.tdqs));
      tdone("park");
      // Pin high with the nominal field off must change nothing
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_0020);
      u_ctl.set_odt(1'b1);
      wt(12);
      st(DTC_PARK);
      chk("rx_en", 32'h0000_0000, 32'(odt_rx_en));
      u_ctl.set_odt(1'b0);
      wt(12);
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_0022);
      wt(3);
      chk("rx_en", 32'h0000_0001, 32'(odt_rx_en));
      u_ctl.set_odt(1'b1);
      wt(5);
      st(DTC_PARK);
      wt(5);
      st(DTC_NOM);
      chk("ohms", 32'(`DTC_OHM_120), 32'(term.ohms));
      tdone("nom");
      // Clock enable low freezes the state, the pin path and the bus
      u_ctl.set_cke(1'b0);
      u_ctl.set_odt(1'b0);
      wt(12);
      st(DTC_NOM);
      chk("hreadyout", 32'h0000_0000, 32'(hreadyout));
      u_ctl.set_cke(1'b1);
      wt(12);
      st(DTC_PARK);
      chk("hresp", 32'h0000_0000, 32'(hresp));
      tdone("cke");
      // Write termination with the pin low, then every preamble and CRC mix with it high
      u_ctl.set_odt(1'b0);
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_002A);
      wt(12);
      win(DTC_CMD_WR, 1'b0, 7, 6, DTC_WRT, DTC_PARK);
      u_ctl.set_odt(1'b1);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `DTC_ADDR_MODE, mtab[i]);
         wt(12);
         win(DTC_CMD_WR, 1'b0, wst[i], wln[i], DTC_WRT, DTC_NOM);
         win(DTC_CMD_RD, 1'b0, rst[i], rln[i], DTC_HIZ, DTC_NOM);
      end
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_002A);
      wt(12);
      win(DTC_CMD_WR, 1'b1, 7, 4, DTC_WRT, DTC_NOM);
      win(DTC_CMD_RD, 1'b1, 13, 4, DTC_HIZ, DTC_NOM);
      bus(1'b1, `DTC_ADDR_MODE, 32'h0000_0022);
      wt(3);
      win(DTC_CMD_WR, 1'b0, 7, 6, DTC_NOM, DTC_NOM);
      tdone("windows");
      // Self-refresh overrides the pin and refuses reads
      u_ctl.issue(DTC_CMD_SRE, 1'b0);
      wt(3);
      st(DTC_HIZ);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0034, "status");
      win(DTC_CMD_RD, 1'b0, 0, 0, DTC_HIZ, DTC_HIZ);
      u_ctl.issue(DTC_CMD_SRX, 1'b0);
      wt(12);
      st(DTC_NOM);
      tdone("selfref");
      // Calibration keeps the parked value while busy
      u_ctl.set_odt(1'b0);
      bus(1'b1, `DTC_ADDR_ZQLEN, 32'h0000_0010);
      wt(12);
      st(DTC_PARK);
      u_ctl.issue(DTC_CMD_ZQCL, 1'b0);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0039, "status");
      st(DTC_PARK);
      wt(20);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0031, "status");
      u_ctl.issue(DTC_CMD_ZQCS, 1'b0);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0039, "status");
      // A pin raised mid-calibration is a controller fault; the flag sticks until cleared
      u_ctl.set_odt(1'b1);
      wt(3);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0139, "status");
      u_ctl.set_odt(1'b0);
      wt(20);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0131, "status");
      bus(1'b1, `DTC_ADDR_STATUS, 32'h0000_0100);
      rreg(`DTC_ADDR_STATUS, 32'h0000_0031, "status");
      tdone("zq");
      end_sim();
   end
endmodule
`default_nettype wire
